/* hdl/high_side_switch_control.v */
// four-channel high-side switch control with AXI4-Lite registers
`include "high_side_switch_consts.vh"

module high_side_switch_control #(
	parameter OC_CYC = `OC_FILTER_CYC,	// overcurrent filter cycles
	parameter OL_CYC = `OL_FILTER_CYC	// open-load filter cycles
) (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [7:0]  s_axi_awaddr,
	// axi4-lite write data
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	output wire [1:0]  s_axi_bresp,
	// axi4-lite read address
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	input  wire [7:0]  s_axi_araddr,
	// axi4-lite read data
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	// chip mode from the mode controller (same clock)
	input  wire [2:0]  chip_mode,
	// internal timer and pwm sources (same clock)
	input  wire        timer1,
	input  wire        timer2,
	input  wire        pwm1,
	input  wire        pwm2,
	// analog comparators (asynchronous)
	input  wire        supply_ov_cmp,
	input  wire        supply_uv_cmp,
	input  wire [3:0]  overcurrent_cmp,
	input  wire [3:0]  open_load_cmp,
	// switch drive and interrupt
	output wire [3:0]  high_side_output,
	output wire        irq
);

	// ==========================================================
	// pin input synchronisers
	reg  [9:0] sync1_ff;	// first stage, read only by stage two
	reg  [9:0] sync2_ff;	// second stage
	reg  [9:0] sync3_ff;	// third stage
	reg  [9:0] filt_ff;	// accepted level
	// comparator bit order: ov, uv, oc[3:0], ol[3:0]
	wire [9:0] raw_in = {open_load_cmp, overcurrent_cmp, supply_uv_cmp, supply_ov_cmp};

	// each comparator crosses from the analog side through three stages;
	// the accepted level moves only when stages two and three agree, so a
	// glitch that reaches stage two alone is never acted on
	always @(posedge aclk) begin
		if (!aresetn) begin
			sync1_ff <= 10'h000;
			sync2_ff <= 10'h000;
			sync3_ff <= 10'h000;
			filt_ff  <= 10'h000;
		end else begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			filt_ff  <= (sync2_ff & sync3_ff) | (filt_ff & (sync2_ff | sync3_ff));
		end
	end

	// filtered comparator levels, three to four cycles behind the pins
	wire       ov_now = filt_ff[0];
	wire       uv_now = filt_ff[1];
	wire [3:0] oc_now = filt_ff[5:2];
	wire [3:0] ol_now = filt_ff[9:6];

	// ==========================================================
	// registers
	reg  [11:0] cfg_ff;		// 3 bits per output
	reg  [2:0]  supply_ctrl_ff;	// ov disable, uv disable, recovery
	reg  [3:0]  oc_flag_ff;		// overcurrent flags
	reg  [3:0]  ol_flag_ff;		// open-load flags
	reg  [1:0]  sv_flag_ff;		// supply uv, ov flags
	reg  [3:0]  irq_stat_ff;	// sticky event status
	reg  [3:0]  irq_mask_ff;	// interrupt mask
	reg  [3:0]  drive_ff;		// registered switch drive
	reg  [31:0] rdata_ff;		// read data
	reg  [1:0]  rresp_ff;		// read response
	reg         rvalid_ff;		// read data valid
	reg         bvalid_ff;		// write response valid
	reg  [1:0]  bresp_ff;		// write response
	reg         aw_got_ff;		// write address held
	reg         w_got_ff;		// write data held
	reg  [7:0]  awaddr_ff;		// held write address
	reg  [31:0] wdata_ff;		// held write data
	reg  [3:0]  wstrb_ff;		// held strobes
	reg  [1:0]  fault_prev_ff;	// supply fault a cycle ago

	// ==========================================================
	// axi4-lite handshakes
	// ready outputs come straight from held state: a channel that has delivered
	// its item, or a response not yet taken, blocks new items
	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready  = !w_got_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs  = s_axi_wvalid && s_axi_wready;
	wire ar_hs = s_axi_arvalid && s_axi_arready;

	// current address, data and strobes whether just taken or held
	wire [7:0]  wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
	wire [31:0] wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
	wire [3:0]  wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
	wire        wr_go   = (aw_got_ff || aw_hs) && (w_got_ff || w_hs);

	wire wr_map = (wr_addr == `OFS_CTRL_A) || (wr_addr == `OFS_CTRL_B) ||
		(wr_addr == `OFS_SUPPLY_CTRL) || (wr_addr == `OFS_OC_STAT) ||
		(wr_addr == `OFS_OL_STAT) || (wr_addr == `OFS_IRQ_MASK);

	// config writes only accepted in normal, restart or fail-safe; in stop
	// and sleep they are answered with okay but dropped, which keeps the
	// frozen setup intact, while restart and fail-safe take them so that
	// software can prepare the outputs for the return to normal
	wire low_power = (chip_mode == `MODE_STOP) || (chip_mode == `MODE_SLEEP);
	wire forced_off = (chip_mode == `MODE_RESTART) || (chip_mode == `MODE_FAILSAFE);
	wire cfg_wr_ok = !low_power;

	wire wr_ctrl_a = wr_go && wr_addr == `OFS_CTRL_A && wr_strb[0] && cfg_wr_ok;
	wire wr_ctrl_b = wr_go && wr_addr == `OFS_CTRL_B && wr_strb[0] && cfg_wr_ok;
	wire wr_sctl   = wr_go && wr_addr == `OFS_SUPPLY_CTRL && wr_strb[0] && cfg_wr_ok;
	wire wr_oc     = wr_go && wr_addr == `OFS_OC_STAT && wr_strb[0];
	wire wr_ol     = wr_go && wr_addr == `OFS_OL_STAT && wr_strb[0];
	wire wr_mask   = wr_go && wr_addr == `OFS_IRQ_MASK && wr_strb[0];
	// taking the address of the interrupt status clears it
	wire rd_irq    = ar_hs && s_axi_araddr == `OFS_IRQ_STAT;

	// ==========================================================
	// supply fault logic
	wire ov_act = ov_now && !supply_ctrl_ff[`SC_OV_DIS];
	wire uv_act = uv_now && !supply_ctrl_ff[`SC_UV_DIS];
	wire supply_fault = ov_act || uv_act;	// any enabled supply fault
	// without the recovery bit every config is cleared while the fault
	// lasts, so the outputs stay off once the supply is good again; with
	// it the configs are untouched and the drive comes back by itself
	wire clear_all = supply_fault && !supply_ctrl_ff[`SC_REC];

	// ==========================================================
	// per-output source select, overcurrent and open-load filters
	reg  [3:0] src_on;	// requested level from chosen source
	reg  [3:0] oc_trip;	// overcurrent filter expired
	reg  [3:0] ol_trip;	// open-load filter expired
	reg  [10:0] oc_cnt_ff [0:3];	// overcurrent time counters
	reg  [12:0] ol_cnt_ff [0:3];	// open-load time counters
	// counters are sized for the default filter times; longer ones need wider counters
	integer i;	// loop index, source select
	integer j;	// loop index, filter counters
	integer k;	// loop index, config update

	// pick the source of each output from its config code
	// codes 6 and 7 are unused and keep the output off
	// an overcurrent trip rises as the filter expires; drive and config drop one edge later
	always @* begin
		for (i = 0; i < 4; i = i + 1) begin
			case (cfg_ff[i*3 +: 3])
				`CFG_ON:   src_on[i] = 1'b1;
				`CFG_TMR1: src_on[i] = timer1;
				`CFG_TMR2: src_on[i] = timer2;
				`CFG_PWM1: src_on[i] = pwm1;
				`CFG_PWM2: src_on[i] = pwm2;
				default:   src_on[i] = 1'b0;
			endcase
			oc_trip[i] = oc_now[i] && drive_ff[i] &&
				(oc_cnt_ff[i] >= OC_CYC[10:0] - 11'h001);
			ol_trip[i] = ol_now[i] && drive_ff[i] &&
				(ol_cnt_ff[i] >= OL_CYC[12:0] - 13'h0001);
		end
	end

	// the filter counters run only while the condition and drive last;
	// they restart at zero whenever either drops, and hold at the limit
	// so that an open-load trip stays up while the condition does; an overcurrent trip lasts one cycle
	always @(posedge aclk) begin
		for (j = 0; j < 4; j = j + 1) begin
			// overcurrent filter
			if (!aresetn || !oc_now[j] || !drive_ff[j])
				oc_cnt_ff[j] <= 11'h000;
			else if (!oc_trip[j])
				oc_cnt_ff[j] <= oc_cnt_ff[j] + 11'h001;
			// open-load filter
			if (!aresetn || !ol_now[j] || !drive_ff[j])
				ol_cnt_ff[j] <= 13'h0000;
			else if (!ol_trip[j])
				ol_cnt_ff[j] <= ol_cnt_ff[j] + 13'h0001;
		end
	end

	// ==========================================================
	// configuration and flag registers
	reg [11:0] nxt_cfg;
	reg [3:0]  nxt_oc_flag;
	reg [3:0]  nxt_ol_flag;

	// writes, then hardware clears and sets, which win over writes
	// so an event that meets a software clear in one cycle is never lost
	always @* begin
		nxt_cfg = cfg_ff;
		if (wr_ctrl_a)
			nxt_cfg[5:0] = {wr_data[6:4], wr_data[2:0]};
		if (wr_ctrl_b)
			nxt_cfg[11:6] = {wr_data[6:4], wr_data[2:0]};
		if (clear_all)
			nxt_cfg = 12'h000;
		// a trip clears only the config of its own output
		for (k = 0; k < 4; k = k + 1) begin
			if (oc_trip[k])
				nxt_cfg[k*3 +: 3] = `CFG_OFF;
		end
		// write one to clear, never cleared by hardware
		nxt_oc_flag = (wr_oc ? (oc_flag_ff & ~wr_data[3:0]) : oc_flag_ff) | oc_trip;
		nxt_ol_flag = (wr_ol ? (ol_flag_ff & ~wr_data[3:0]) : ol_flag_ff) | ol_trip;
	end

	// registered state updates
	always @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff         <= 12'h000;
			supply_ctrl_ff <= 3'h0;
			oc_flag_ff     <= 4'h0;
			ol_flag_ff     <= 4'h0;
			sv_flag_ff     <= 2'h0;
			irq_mask_ff    <= 4'h0;
			irq_stat_ff    <= 4'h0;
			drive_ff       <= 4'h0;
			fault_prev_ff  <= 2'h0;
		end else begin
			cfg_ff        <= nxt_cfg;
			oc_flag_ff    <= nxt_oc_flag;
			ol_flag_ff    <= nxt_ol_flag;
			fault_prev_ff <= {uv_act, ov_act};
			if (wr_sctl)
				supply_ctrl_ff <= wr_data[2:0];
			if (wr_mask)
				irq_mask_ff <= wr_data[3:0];
			// supply flags show the live fault only
			sv_flag_ff <= {uv_now, ov_now};
			// sticky events: oc, ol, ov, uv; set wins over read clear
			irq_stat_ff <= (rd_irq ? 4'h0 : irq_stat_ff) |
				{uv_act && !fault_prev_ff[1], ov_act && !fault_prev_ff[0],
				 |ol_trip, |oc_trip};
			// registered so the pins never glitch while a source or a fault changes
			// drive: off when forced or on supply fault
			drive_ff <= (forced_off || supply_fault) ? 4'h0 : (src_on & ~oc_trip);
		end
	end

	assign high_side_output = drive_ff;
	// level interrupt, high while any unmasked status bit is set
	assign irq = |(irq_stat_ff & irq_mask_ff);

	// ==========================================================
	// axi4-lite write channel
	// address and data may come in either order; each is held until the
	// other arrives, and the response then blocks both until it is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= `RESP_OKAY;
		end else begin
			if (aw_hs)
				awaddr_ff <= s_axi_awaddr;
			if (w_hs) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
			end else begin
				aw_got_ff <= aw_got_ff || aw_hs;
				w_got_ff  <= w_got_ff || w_hs;
				if (bvalid_ff && s_axi_bready)
					bvalid_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// axi4-lite read channel
	reg [31:0] rd_mux;
	reg        rd_hit;

	// read data selection
	always @* begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`OFS_CTRL_A:      rd_mux = {25'h0, cfg_ff[5:3], 1'b0, cfg_ff[2:0]};
			`OFS_CTRL_B:      rd_mux = {25'h0, cfg_ff[11:9], 1'b0, cfg_ff[8:6]};
			`OFS_SUPPLY_CTRL: rd_mux = {29'h0, supply_ctrl_ff};
			`OFS_OC_STAT:     rd_mux = {28'h0, oc_flag_ff};
			`OFS_OL_STAT:     rd_mux = {28'h0, ol_flag_ff};
			`OFS_SUPPLY_STAT: rd_mux = {30'h0, sv_flag_ff};
			`OFS_IRQ_STAT:    rd_mux = {28'h0, irq_stat_ff};
			`OFS_IRQ_MASK:    rd_mux = {28'h0, irq_mask_ff};
			default: begin
				rd_mux = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// read answer one cycle after the address is taken
	// arready is low while the answer stands, so a second read waits for it
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= `RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_mux;
			rresp_ff  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

endmodule // high_side_switch_control

/* hdl/high_side_switch_consts.vh */
// constants for the high-side switch control block
// Behaviour
// - each output picks direct, timer or PWM source
// - stop/sleep keep config, ignore config writes
// - restart or fail-safe forces all outputs off
// - overvoltage switches outputs off unless disabled
// - undervoltage switches outputs off unless disabled
// - recovery bit restores, else configs cleared
// - supply faults set only their two flags
// - overcurrent beyond filter time switches output off
// - overcurrent sets flag, resets config to 000
// - overcurrent flags held until software clears
// - open load while on sets flag, output stays
// - open-load flags held until software clears
// - after forced off, writes re-enable outputs
`ifndef HIGH_SIDE_SWITCH_CONSTS_VH
`define HIGH_SIDE_SWITCH_CONSTS_VH

// ==========================================================
// register byte offsets
`define OFS_CTRL_A      8'h00
`define OFS_CTRL_B      8'h04
`define OFS_SUPPLY_CTRL 8'h08
`define OFS_OC_STAT     8'h0C
`define OFS_OL_STAT     8'h10
`define OFS_SUPPLY_STAT 8'h14
`define OFS_IRQ_STAT    8'h18
`define OFS_IRQ_MASK    8'h1C

// ==========================================================
// configuration codes
`define CFG_OFF   3'h0
`define CFG_ON    3'h1
`define CFG_TMR1  3'h2
`define CFG_TMR2  3'h3
`define CFG_PWM1  3'h4
`define CFG_PWM2  3'h5

// supply control bit positions
`define SC_OV_DIS 0
`define SC_UV_DIS 1
`define SC_REC    2

// chip modes
`define MODE_NORMAL   3'h0
`define MODE_STOP     3'h1
`define MODE_SLEEP    3'h2
`define MODE_RESTART  3'h3
`define MODE_FAILSAFE 3'h4

// ==========================================================
// timing
`define CLK_MHZ        50
`define OC_FILTER_US   16
`define OC_FILTER_CYC  (`OC_FILTER_US * `CLK_MHZ)
`define OL_FILTER_US   64
`define OL_FILTER_CYC  (`OL_FILTER_US * `CLK_MHZ)

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

/* tb/switch_load_model.sv */
// load model turning switch states into current comparator levels
module switch_load_model (
	// switch drive from the block
	input wire logic [3:0] high_side_output,
	// fault selection from the bench
	input wire logic [3:0] short_load,
	input wire logic [3:0] open_load,
	// comparator levels back to the block
	output logic     [3:0] overcurrent_cmp,
	output logic     [3:0] open_load_cmp
);
	timeunit 1ns;
	timeprecision 1ns;
	// current flows only through a switched-on load, so an off switch reads no fault
	assign overcurrent_cmp = high_side_output & short_load;
	assign open_load_cmp = high_side_output & open_load;
endmodule // switch_load_model

/* tb/high_side_switch_chk.sv */
// assertion checker watching the high-side switch control ports
module high_side_switch_chk #(
	parameter int OC_CYC = 8	// overcurrent filter cycles
) (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	// mode, load sense and drive
	input wire logic [2:0]  chip_mode,
	input wire logic [3:0]  overcurrent_cmp,
	input wire logic [3:0]  high_side_output,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int OC_LIM = OC_CYC + 12;	// filter plus synchroniser and drive slack
	// ==========================================
	// clocking
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========================================
	// sequences
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence oc_start;
		$rose(overcurrent_cmp[0]) && high_side_output[0];
	endsequence
	// ==========================================
	// assertions
	wr_answer_a: assert property (wr_taken |=> s_axi_bvalid)
		else $error("write response missing");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read data missing");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	bad_read_a: assert property (rd_taken ##0 (s_axi_araddr > 8'h1C) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read answered");
	reset_idle_a: assert property ($rose(aresetn) |-> high_side_output == 4'h0 && !irq && !s_axi_bvalid)
		else $error("outputs active out of reset");
	forced_off_a: assert property ((chip_mode == 3'h3 || chip_mode == 3'h4) |-> ##[1:2] high_side_output == 4'h0)
		else $error("output on in restart or fail-safe");
	oc_off_a: assert property (oc_start |-> ##[1:OC_LIM] !high_side_output[0])
		else $error("overcurrent output not switched off");
endmodule // high_side_switch_chk

/* tb/high_side_switch_control_tb.sv */
// testbench for the high-side switch control block
module high_side_switch_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// signals
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, overcurrent_cmp, open_load_cmp, high_side_output, short_load, open_load;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  chip_mode;
	logic        timer1, timer2, pwm1, pwm2, supply_ov_cmp, supply_uv_cmp, irq;
	int          fail_count = 0;
	int          comparisons = 0;
	// ==========================================
	// instances
	high_side_switch_control #(.OC_CYC(8), .OL_CYC(16)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .chip_mode(chip_mode),
		.timer1(timer1), .timer2(timer2), .pwm1(pwm1), .pwm2(pwm2), .supply_ov_cmp(supply_ov_cmp),
		.supply_uv_cmp(supply_uv_cmp), .overcurrent_cmp(overcurrent_cmp),
		.open_load_cmp(open_load_cmp), .high_side_output(high_side_output), .irq(irq));
	switch_load_model load_u (.high_side_output(high_side_output), .short_load(short_load),
		.open_load(open_load), .overcurrent_cmp(overcurrent_cmp), .open_load_cmp(open_load_cmp));
	// ==========================================
	// helpers
	task automatic final_report();
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic ok, input string s);
		comparisons++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED %0t %s", $time, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// one bus transfer; ready is sampled mid-cycle, where it already holds its edge value
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic [1:0] r);
		logic ta, tw, tr, done;
		done = 1'b0;
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		end else begin
			s_axi_araddr <= a;
			{s_axi_arvalid, s_axi_rready} <= 2'h3;
		end
		repeat (50) if (!done) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tr = s_axi_arvalid && s_axi_arready;
			done = w ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			r = w ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tr) s_axi_arvalid <= 1'b0;
			if (done) {s_axi_bready, s_axi_rready} <= 2'h0;
		end
		// one edge passes so that a following call never reassigns a signal in this step
		@(posedge aclk);
		chk(done, "bus answer missing");
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic [1:0]  r;
		xfer(1'b1, a, d, q, r);
		chk(r === 2'h0, "write refused");
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string s);
		logic [31:0] q;
		logic [1:0]  r;
		xfer(1'b0, a, 32'h0, q, r);
		chk((q & m) === e && r === 2'h0, s);
	endtask
	// compares {irq, outputs} where they are settled
	task automatic pin_chk(input logic [4:0] e, input string s);
		@(negedge aclk);
		chk({irq, high_side_output} === e, s);
		@(posedge aclk);
	endtask
	// ==========================================
	// scenarios
	task automatic t_sources();
		logic [3:0]  src;
		logic        e;
		logic [31:0] q;
		logic [1:0]  r;
		for (int p = 0; p < 2; p++) begin
			src = p ? 4'hA : 4'h5;
			{pwm2, pwm1, timer2, timer1} <= src;
			for (int c = 0; c < 8; c++) begin
				e = (c == 1) || (c > 1 && c < 6 && src[c-2]);
				wr(8'h00, {25'h0, c[2:0], 1'b0, c[2:0]});
				tick(1);
				pin_chk({3'h0, e, e}, "source select");
				rd_chk(8'h00, {25'h0, c[2:0], 1'b0, c[2:0]}, 32'h77, "config readback");
			end
		end
		xfer(1'b1, 8'h20, 32'h1, q, r);
		chk(r === 2'h2, "unmapped write accepted");
		xfer(1'b0, 8'h20, 32'h0, q, r);
		chk(q === 32'h0 && r === 2'h2, "unmapped read answered");
	endtask
	task automatic t_modes();
		for (int m = 1; m < 3; m++) begin
			wr(8'h00, 32'h1);
			chip_mode <= m[2:0];
			tick(1);
			wr(8'h00, 32'h0);
			tick(1);
			pin_chk(5'h01, "config not frozen");
			rd_chk(8'h00, 32'h1, 32'h7, "config changed in low power");
			chip_mode <= 3'h0;
		end
		for (int m = 3; m < 5; m++) begin
			chip_mode <= m[2:0];
			tick(2);
			pin_chk(5'h00, "output not forced off");
			chip_mode <= 3'h0;
			wr(8'h00, 32'h0);
			rd_chk(8'h00, 32'h0, 32'h7, "config write refused after forced off");
			wr(8'h00, 32'h1);
			tick(1);
			pin_chk(5'h01, "output not re-enabled");
		end
	endtask
	task automatic t_supply();
		wr(8'h08, 32'h4);
		supply_ov_cmp <= 1'b1;
		tick(6);
		pin_chk(5'h00, "overvoltage not off");
		rd_chk(8'h14, 32'h1, 32'h3, "overvoltage flag");
		rd_chk(8'h0C, 32'h0, 32'hF, "overcurrent flag on supply fault");
		rd_chk(8'h10, 32'h0, 32'hF, "open-load flag on supply fault");
		supply_ov_cmp <= 1'b0;
		tick(6);
		pin_chk(5'h01, "not restored");
		wr(8'h08, 32'h5);
		supply_ov_cmp <= 1'b1;
		tick(6);
		pin_chk(5'h01, "overvoltage shutdown not disabled");
		supply_ov_cmp <= 1'b0;
		tick(6);
		pin_chk(5'h01, "output lost while shutdown disabled");
		wr(8'h08, 32'h0);
		supply_uv_cmp <= 1'b1;
		tick(6);
		pin_chk(5'h00, "undervoltage not off");
		supply_uv_cmp <= 1'b0;
		tick(6);
		pin_chk(5'h00, "output back without recovery");
		rd_chk(8'h00, 32'h0, 32'h7, "config not cleared");
		wr(8'h08, 32'h6);
		wr(8'h00, 32'h1);
		supply_uv_cmp <= 1'b1;
		tick(6);
		pin_chk(5'h01, "undervoltage shutdown not disabled");
		supply_uv_cmp <= 1'b0;
	endtask
	task automatic t_overcurrent();
		short_load <= 4'h1;
		tick(25);
		pin_chk(5'h00, "overcurrent not off or irq unmasked");
		rd_chk(8'h0C, 32'h1, 32'hF, "overcurrent flag");
		rd_chk(8'h00, 32'h0, 32'h7, "config not reset");
		short_load <= 4'h0;
		wr(8'h1C, 32'h1);
		tick(1);
		pin_chk(5'h10, "irq not raised");
		rd_chk(8'h18, 32'h1, 32'h1, "irq cause");
		pin_chk(5'h00, "irq not cleared by read");
		rd_chk(8'h0C, 32'h1, 32'hF, "overcurrent flag lost");
		wr(8'h0C, 32'h1);
		rd_chk(8'h0C, 32'h0, 32'hF, "overcurrent flag not cleared");
		wr(8'h00, 32'h1);
		tick(1);
		pin_chk(5'h01, "not reactivated");
	endtask
	task automatic t_open_load();
		open_load <= 4'h1;
		tick(30);
		pin_chk(5'h01, "open load switched off");
		rd_chk(8'h10, 32'h1, 32'hF, "open-load flag");
		open_load <= 4'h0;
		tick(6);
		rd_chk(8'h10, 32'h1, 32'hF, "open-load flag lost");
		wr(8'h10, 32'h1);
		rd_chk(8'h10, 32'h0, 32'hF, "open-load flag not cleared");
	endtask
	// ==========================================
	// clock, watchdog and main sequence
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	initial begin
		#120000;
		fail_count++;
		final_report();
	end
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0, 4'hF};
		{chip_mode, short_load, open_load} = 11'h000;
		{timer1, timer2, pwm1, pwm2, supply_ov_cmp, supply_uv_cmp} = 6'h00;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		tick(1);
		t_sources();
		t_modes();
		t_supply();
		t_overcurrent();
		t_open_load();
		final_report();
	end
endmodule // high_side_switch_control_tb
bind high_side_switch_control high_side_switch_chk #(.OC_CYC(OC_CYC)) chk_u (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .chip_mode(chip_mode), .overcurrent_cmp(overcurrent_cmp),
	.high_side_output(high_side_output), .irq(irq));
